//--- hdl/dpio_top.sv
`timescale 1ns/1ps
`default_nettype none
module dpio_top (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Register bus
    input wire dpio_pkg::dpio_bus_req_t BUS_I,
    output logic [7:0] RDATA_O,
    // Bidirectional port pins
    input wire logic [7:0] PA_IN_I,
    output logic [7:0] PA_OUT_O,
    output logic [7:0] PA_OE_O,
    // Input-only port pins
    input wire logic [7:0] PE_IN_I,
    // Converter control
    output logic CONVERTER_POWER_UP_O
);
    import dpio_pkg::*;

    logic [7:0] port_a_data;
    logic [7:0] port_a_direction;
    logic [7:0] option;
    logic [7:0] rdata;
    logic [7:0] next_port_a_data;
    logic [7:0] next_port_a_direction;
    logic [7:0] next_option;
    logic [7:0] next_rdata;
    logic [7:0] pa_sync;
    logic [7:0] pe_sync;
    logic [7:0] pa_read;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    dpio_sync #(.WIDTH(8)) u_sync_a (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i(PA_IN_I),
        .q_o(pa_sync)
    );

    dpio_sync #(.WIDTH(8)) u_sync_e (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i(PE_IN_I),
        .q_o(pe_sync)
    );

    // ****************************************
    // Register file
    // ****************************************
    // Output pins read back latch, input pins read level
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pa_read[i] = port_a_direction[i] ? port_a_data[i] : pa_sync[i]; // see RULE_03
        end
    end

    // Next register values and read mux
    always_comb
    begin
        next_port_a_data = port_a_data;
        next_port_a_direction = port_a_direction;
        next_option = option;
        next_rdata = 8'h00;
        if (BUS_I.wr)
        begin
            unique case (BUS_I.addr)
                OFS_PORT_A_PIN_DATA: next_port_a_data = BUS_I.wdata; // see RULE_07
                OFS_PORT_A_DIRECTION: next_port_a_direction = BUS_I.wdata; // see RULE_01
                OFS_OPTION: next_option = BUS_I.wdata; // see RULE_05
                default: ;
            endcase
        end
        if (BUS_I.rd)
        begin
            unique case (BUS_I.addr)
                OFS_PORT_A_PIN_DATA: next_rdata = pa_read;
                OFS_PORT_A_DIRECTION: next_rdata = port_a_direction;
                // Converter mode leaves no digital reading
                OFS_PORT_E_INPUT_DATA:
                    next_rdata = option[OPT_CONVERTER_POWER_UP_BIT] ? 8'h00 : pe_sync; // see RULE_04
                OFS_OPTION: next_rdata = option;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            port_a_data <= RST_PORT_A_DATA;
            port_a_direction <= RST_PORT_A_DIRECTION; // see RULE_06
            option <= RST_OPTION; // see RULE_04
            rdata <= 8'h00;
        end
        else
        begin
            port_a_data <= next_port_a_data;
            port_a_direction <= next_port_a_direction;
            option <= next_option;
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // Outputs straight from flops
    // ****************************************
    assign RDATA_O = rdata;
    assign PA_OUT_O = port_a_data; // see RULE_02
    assign PA_OE_O = port_a_direction; // see RULE_01
    assign CONVERTER_POWER_UP_O = option[OPT_CONVERTER_POWER_UP_BIT]; // see RULE_05

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Power-up bit must sit inside the option byte
    if (OPT_CONVERTER_POWER_UP_BIT > 7)
    begin : g_bad_power_up_bit
        $error("converter power-up bit outside the option register");
    end

    // Offsets need a four-bit address
    if (ADDR_W < 4)
    begin : g_bad_addr_width
        $error("address too narrow for the register offsets");
    end

    // ****************************************
    // Bus events for the checks
    // ****************************************
    // Write to the data latch
    sequence s_data_write;
        BUS_I.wr && BUS_I.addr == OFS_PORT_A_PIN_DATA;
    endsequence : s_data_write

    // Write that turns every pin to output
    sequence s_dir_all_out;
        BUS_I.wr && BUS_I.addr == OFS_PORT_A_DIRECTION && BUS_I.wdata == 8'hFF;
    endsequence : s_dir_all_out

    // Read of the data register
    sequence s_data_read;
        BUS_I.rd && BUS_I.addr == OFS_PORT_A_PIN_DATA;
    endsequence : s_data_read

    // Read of the direction register
    sequence s_dir_read;
        BUS_I.rd && BUS_I.addr == OFS_PORT_A_DIRECTION;
    endsequence : s_dir_read

    // Read of the option register
    sequence s_option_read;
        BUS_I.rd && BUS_I.addr == OFS_OPTION;
    endsequence : s_option_read

    // Write to the read-only second port
    sequence s_port_e_write;
        BUS_I.wr && BUS_I.addr == OFS_PORT_E_INPUT_DATA;
    endsequence : s_port_e_write

    // ****************************************
    // Write checks
    // ****************************************
    // Direction write reaches the enables
    a_dir_drives_oe: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_01
        BUS_I.wr && BUS_I.addr == OFS_PORT_A_DIRECTION |=> PA_OE_O == $past(BUS_I.wdata))
        else $error("direction write not seen on enables");

    // Data write reaches the pins
    a_data_drives_pin: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_02
        BUS_I.wr && BUS_I.addr == OFS_PORT_A_PIN_DATA |=> PA_OUT_O == $past(BUS_I.wdata))
        else $error("data write not seen on pins");

    // Power-up bit follows its write
    a_conv_power_up: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_05
        BUS_I.wr && BUS_I.addr == OFS_OPTION
        |=> CONVERTER_POWER_UP_O == $past(BUS_I.wdata[OPT_CONVERTER_POWER_UP_BIT]))
        else $error("power-up bit not applied");

    // Latch written while input shows once output
    a_latch_while_input: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_07
        s_data_write ##1 s_dir_all_out
        |=> PA_OUT_O == $past(BUS_I.wdata, 2) && PA_OE_O == 8'hFF)
        else $error("latched value lost");

    // Direction only moves on a direction write
    a_dir_holds: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_06
        !RST_I && !(BUS_I.wr && BUS_I.addr == OFS_PORT_A_DIRECTION) |=> $stable(PA_OE_O))
        else $error("direction changed without a write");

    // Pin drive only moves on a data write
    a_data_holds: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_07
        !RST_I && !(BUS_I.wr && BUS_I.addr == OFS_PORT_A_PIN_DATA) |=> $stable(PA_OUT_O))
        else $error("pin drive changed without a write");

    // Power-up bit only moves on an option write
    a_option_holds: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_05
        !RST_I && !(BUS_I.wr && BUS_I.addr == OFS_OPTION) |=> $stable(CONVERTER_POWER_UP_O))
        else $error("power-up bit changed without a write");

    // Writes to the input-only port change nothing
    a_port_e_readonly: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_04
        s_port_e_write |=> $stable(PA_OUT_O) && $stable(PA_OE_O) && $stable(CONVERTER_POWER_UP_O))
        else $error("write to input-only port had an effect");

    // Writes outside the map change nothing
    a_unmapped_no_write: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        BUS_I.wr && BUS_I.addr[1:0] != 2'h0
        |=> $stable(PA_OUT_O) && $stable(PA_OE_O) && $stable(CONVERTER_POWER_UP_O))
        else $error("unmapped write had an effect");

    // Converter turns on only through an option write
    a_conv_rise_cause: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_05
        $rose(CONVERTER_POWER_UP_O) |-> $past(BUS_I.wr) && $past(BUS_I.addr) == OFS_OPTION)
        else $error("converter powered up without a write");

    // ****************************************
    // Read checks
    // ****************************************
    // Input pins read their level
    a_input_read_level: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_03
        BUS_I.rd && BUS_I.addr == OFS_PORT_A_PIN_DATA && PA_OE_O == 8'h00
        |=> RDATA_O == $past(pa_sync))
        else $error("input read wrong");

    // Second port reads its pins while digital
    a_port_e_digital: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_04
        BUS_I.rd && BUS_I.addr == OFS_PORT_E_INPUT_DATA && !CONVERTER_POWER_UP_O
        |=> RDATA_O == $past(pe_sync))
        else $error("second port read wrong");

    // Reads outside the map return zero
    a_unmapped_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        BUS_I.rd && BUS_I.addr[1:0] != 2'h0 |=> RDATA_O == 8'h00)
        else $error("unmapped read not zero");

    // Direction register reads back as written
    a_dir_readback: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_01
        s_dir_read |=> RDATA_O == $past(PA_OE_O))
        else $error("direction read back wrong");

    // Each bit reads latch or pin by its own direction
    a_mixed_read: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_01
        s_data_read
        |=> RDATA_O == (($past(PA_OE_O) & $past(PA_OUT_O))
            | (~$past(PA_OE_O) & $past(pa_sync))))
        else $error("per-bit read wrong");

    // An output pin reads back its drive level
    a_output_readback: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_02
        s_data_read ##0 PA_OE_O == 8'hFF |=> RDATA_O == $past(PA_OUT_O))
        else $error("output read back wrong");

    // Converter mode leaves the second port reading zero
    a_analog_reads_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_05
        BUS_I.rd && BUS_I.addr == OFS_PORT_E_INPUT_DATA && CONVERTER_POWER_UP_O
        |=> RDATA_O == 8'h00)
        else $error("second port read not zero in converter mode");

    // Option register shows the power-up state
    a_option_readback: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_05
        s_option_read |=> RDATA_O[OPT_CONVERTER_POWER_UP_BIT] == $past(CONVERTER_POWER_UP_O))
        else $error("option read back wrong");

    // Read data stand for one cycle only
    a_rdata_one_cycle: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !BUS_I.rd |=> RDATA_O == 8'h00)
        else $error("read data held too long");

    // A write cycle leaves no read data
    a_write_no_rdata: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        BUS_I.wr |=> RDATA_O == 8'h00)
        else $error("read data after a write");

    // ****************************************
    // Reset and synchroniser checks
    // ****************************************
    // Reset makes every pin an input
    a_reset_inputs: assert property (@(posedge CLK_SYS_I) // see RULE_06
        RST_I |=> PA_OE_O == 8'h00 && !CONVERTER_POWER_UP_O)
        else $error("pins not inputs after reset");

    // Reset clears drive and read data
    a_reset_clears: assert property (@(posedge CLK_SYS_I) // see RULE_06
        RST_I |=> PA_OUT_O == 8'h00 && RDATA_O == 8'h00)
        else $error("drive or read data not cleared by reset");

    // Port A levels pass two flops before use
    a_sync_port_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_03
        !RST_I ##1 !RST_I |=> pa_sync == $past(PA_IN_I, 2))
        else $error("port A synchroniser delay wrong");

    // Second port levels pass two flops before use
    a_sync_port_e: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see RULE_04
        !RST_I ##1 !RST_I |=> pe_sync == $past(PE_IN_I, 2))
        else $error("second port synchroniser delay wrong");
endmodule : dpio_top
`default_nettype wire

//--- hdl/dpio_pkg.sv
// What this block does
// (RULE_01) Each direction bit makes its bidirectional pin an output when 1 and an input when 0.
// (RULE_02) An output pin is driven low for a data bit of 0 and high for a data bit of 1.
// (RULE_03) Reading a data register returns 0 for a low input pin and 1 for a high input pin.
// (RULE_04) The second port is an 8-bit input-only port, digital after reset, read through its data register.
// (RULE_05) Setting the converter power-up bit turns the second port into converter input; clearing it returns it to digital.
// (RULE_06) After reset every bidirectional pin is an input until software sets its direction bit.
// (RULE_07) Writes to the bidirectional data register latch every bit, so the value shows once the pin turns output.
package dpio_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_PORT_A_PIN_DATA = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PORT_A_DIRECTION = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PORT_E_INPUT_DATA = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_OPTION = 4'hC;
    localparam int OPT_CONVERTER_POWER_UP_BIT = 7;
    localparam logic [7:0] RST_PORT_A_DATA = 8'h00;
    localparam logic [7:0] RST_PORT_A_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h00;

    // ****************************************
    // Register bus carrier
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dpio_bus_req_t;
endpackage : dpio_pkg

//--- hdl/dpio_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a bus of pin levels
module dpio_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;

    // Refuse an empty bus
    if (WIDTH < 1)
    begin : g_bad_width
        $error("synchroniser width must be at least one");
    end

    // First and second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            stable <= '0;
        end
        else
        begin
            meta <= d_i;
            stable <= meta;
        end
    end

    assign q_o = stable;
endmodule : dpio_sync
`default_nettype wire

//--- test/dpio_pins.sv
`timescale 1ns/1ps
`default_nettype none
// Switches and LEDs wired to the pins
module dpio_pins (
    // Pins from the block
    input wire logic [7:0] pa_out_i,
    input wire logic [7:0] pa_oe_i,
    // Switch levels set by the bench
    input wire logic [7:0] sw_a_i,
    input wire logic [7:0] sw_e_i,
    // Levels seen by the block
    output logic [7:0] pa_in_o,
    output logic [7:0] pe_in_o
);
    // A driven pin wins over its switch
    assign pa_in_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & sw_a_i);
    assign pe_in_o = sw_e_i;
endmodule : dpio_pins
`default_nettype wire

//--- test/dpio_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dpio_top_tb;
    import dpio_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dpio_bus_req_t bus = '0;
    logic [7:0] rdata, pa_in, pa_out, pa_oe, pe_in, rv;
    logic [7:0] sw_a = 8'h3C;
    logic [7:0] sw_e = 8'h5A;
    logic cpu;
    int n_mismatch = 0;
    int n_compared = 0;
    // Clock at 200 MHz
    always #2.5 clk = ~clk;
    dpio_top dpio_top_i (.CLK_SYS_I(clk), .RST_I(rst), .BUS_I(bus), .RDATA_O(rdata),
        .PA_IN_I(pa_in), .PA_OUT_O(pa_out), .PA_OE_O(pa_oe), .PE_IN_I(pe_in),
        .CONVERTER_POWER_UP_O(cpu));
    dpio_pins dpio_pins_i (.pa_out_i(pa_out), .pa_oe_i(pa_oe), .sw_a_i(sw_a),
        .sw_e_i(sw_e), .pa_in_o(pa_in), .pe_in_o(pe_in));
    task results;
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One-cycle write, outputs settled on return
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : wr
    // One-cycle read, data taken in the cycle after
    task rd(input logic [3:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        rv = rdata;
        @(posedge clk);
        #1;
        chk("rd_idle", 8'h00, rdata);
    endtask : rd
    // Two writes back to back, no idle cycle between
    task wr_pair(input logic [3:0] a0, input logic [7:0] d0, input logic [3:0] a1,
        input logic [7:0] d1);
        @(posedge clk);
        bus <= '{addr: a0, wdata: d0, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: a1, wdata: d1, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : wr_pair
    task t_reset;
        rd(OFS_PORT_A_DIRECTION);
        chk("dir", 8'h00, rv);
        chk("oe", 8'h00, pa_oe);
        chk("cpu", 8'h00, {7'h0, cpu});
    endtask : t_reset
    task t_latch;
        wr(OFS_PORT_A_PIN_DATA, 8'hA5);
        chk("out", 8'hA5, pa_out);
        chk("oe0", 8'h00, pa_oe);
        wr(OFS_PORT_A_DIRECTION, 8'h0F);
        chk("oe1", 8'h0F, pa_oe);
        repeat (4) @(posedge clk);
        rd(OFS_PORT_A_PIN_DATA);
        chk("pa", 8'h35, rv);
        wr(OFS_PORT_A_PIN_DATA, 8'h5A);
        chk("out2", 8'h5A, pa_out);
        rd(OFS_PORT_A_DIRECTION);
        chk("dir_rb", 8'h0F, rv);
        wr(OFS_PORT_A_DIRECTION, 8'h00);
        @(posedge clk);
        sw_a <= 8'hC3;
        repeat (3) @(posedge clk);
        rd(OFS_PORT_A_PIN_DATA);
        chk("pa_in", 8'hC3, rv);
        wr_pair(OFS_PORT_A_PIN_DATA, 8'h96, OFS_PORT_A_DIRECTION, 8'hFF);
        chk("out3", 8'h96, pa_out);
        chk("oe2", 8'hFF, pa_oe);
        rd(OFS_PORT_A_PIN_DATA);
        chk("pa_drv", 8'h96, rv);
    endtask : t_latch
    task t_port_e;
        rd(OFS_PORT_E_INPUT_DATA);
        chk("pe", 8'h5A, rv);
        wr(OFS_PORT_E_INPUT_DATA, 8'h00);
        chk("ro_out", 8'h96, pa_out);
        chk("ro_oe", 8'hFF, pa_oe);
        wr(OFS_OPTION, 8'h80);
        chk("cpu1", 8'h01, {7'h0, cpu});
        rd(OFS_OPTION);
        chk("opt", 8'h80, rv);
        rd(OFS_PORT_E_INPUT_DATA);
        chk("pe_an", 8'h00, rv);
        wr(OFS_OPTION, 8'h00);
        chk("cpu0", 8'h00, {7'h0, cpu});
        rd(OFS_PORT_E_INPUT_DATA);
        chk("pe2", 8'h5A, rv);
        @(posedge clk);
        sw_e <= 8'hA5;
        repeat (3) @(posedge clk);
        rd(OFS_PORT_E_INPUT_DATA);
        chk("pe3", 8'hA5, rv);
        rd(4'h2);
        chk("unmap", 8'h00, rv);
        wr(4'h6, 8'h00);
        chk("unmap_oe", 8'hFF, pa_oe);
    endtask : t_port_e
    // Reset in mid-run returns every pin to input
    task t_restart;
        wr(OFS_OPTION, 8'h80);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("rs_oe", 8'h00, pa_oe);
        chk("rs_out", 8'h00, pa_out);
        chk("rs_cpu", 8'h00, {7'h0, cpu});
        rd(OFS_PORT_A_DIRECTION);
        chk("rs_dir", 8'h00, rv);
        rd(OFS_PORT_E_INPUT_DATA);
        chk("rs_pe", 8'hA5, rv);
    endtask : t_restart
    // Watchdog
    initial
    begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        results();
    end
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_latch();
        t_port_e();
        t_restart();
        results();
    end
endmodule : dpio_top_tb
`default_nettype wire
